// >>> tac_delay_timer.sv
// One-shot delay counter for panel timing phases.
// Assumes count is at least one.
`timescale 1ns/10ps
module tac_delay_timer
  import tac_pkg::*;
(
  // Clock and reset.
  input  wire logic               clock,
  input  wire logic               rst,
  // Control.
  input  wire logic               start,
  input  wire logic [TIMER_W-1:0] count,
  // Status.
  output logic                    running,
  output logic                    done
);
  logic [TIMER_W-1:0] remain;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      remain  <= '0;
      running <= 1'b0;
      done    <= 1'b0;
    end else begin
      done <= running & (remain == '0);
      if (start) begin
        remain  <= count - 1'b1;
        running <= 1'b1;
      end else if (running && remain == '0) begin
        running <= 1'b0;
      end else if (running) begin
        remain <= remain - 1'b1;
      end
    end
  end
endmodule

// >>> tac_host_model.sv
// Host-side serial master model for the register port.
// Assumes the device samples sclk with a 50 MHz clock; one half period is HALF clocks.
`timescale 1ns/10ps
module tac_host_model #(
  parameter int HALF = 4
)(
  // Clock.
  input  wire logic clock,
  // Serial pins.
  output logic      sclk,
  output logic      cs_n,
  output logic      mosi,
  input  wire logic miso
);
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
  end

  // One command byte and one word; chip select stays low for a following pair.
  task automatic xfer(input logic [7:0] cmd, input logic [15:0] wr, output logic [15:0] rd);
    logic [23:0] frame;
    frame = {cmd, wr};
    rd = 16'h0000;
    @(negedge clock);
    cs_n = 1'b0;
    for (int i = 23; i >= 0; i--) begin
      mosi = frame[i];
      repeat (HALF) @(negedge clock);
      if (i < 16) rd[i] = miso;
      sclk = 1'b1;
      repeat (HALF) @(negedge clock);
      sclk = 1'b0;
    end
  endtask

  // A released data line must not keep its last value.
  task automatic release_bus();
    repeat (HALF) @(negedge clock);
    cs_n = 1'b1;
    mosi = ~mosi;
  endtask
endmodule

// >>> tac_pkg.sv
// Shared constants of the touch converter register port.
// Assumes a single 50 MHz clock domain.
package tac_pkg;
  localparam int unsigned CLK_PERIOD_NS = 20;

  function automatic int unsigned ns_to_cyc(input int unsigned ns);
    int unsigned c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int unsigned SETTLE_NS [8] = '{0, 100000, 500000, 1000000,
                                            5000000, 10000000, 50000000, 100000000};
  localparam int unsigned PRECHARGE_NS [8] = '{20000, 84000, 276000, 340000,
                                               1044000, 1108000, 1300000, 1364000};
  localparam int unsigned SENSE_NS [8] = '{32000, 96000, 544000, 608000,
                                           2080000, 2144000, 2592000, 2656000};
  localparam int unsigned LONG_SAMPLE_NS  = 500;
  localparam int unsigned LONG_SAMPLE_CYC = ns_to_cyc(LONG_SAMPLE_NS);
  localparam int unsigned SHORT_SAMPLE_CYC = 1;

  localparam int TIMER_W = 24;

  // Command byte fields.
  localparam int CMD_ID_BIT   = 7;
  localparam int CMD_ADDR_MSB = 6;
  localparam int CMD_ADDR_LSB = 3;
  localparam int CMD_BIAS_BIT = 1;
  localparam int CMD_RW_BIT   = 0;
  localparam logic [3:0] CMD_LAST_BIT  = 4'h7;
  localparam logic [3:0] WORD_LAST_BIT = 4'hF;

  // Register addresses.
  localparam logic [3:0] ADDR_STATUS    = 4'h7;
  localparam logic [3:0] ADDR_THR_FIRST = 4'h8;
  localparam logic [3:0] ADDR_THR_LAST  = 4'hB;
  localparam logic [3:0] ADDR_CFG0      = 4'hC;
  localparam logic [3:0] ADDR_FSTAT     = 4'hF;

  // Configuration register zero fields.
  localparam int CFG_SCAN_BIT   = 15;
  localparam int CFG_STOP_BIT   = 14;
  localparam int CFG_RES_BIT    = 13;
  localparam int CFG_CLK_LSB    = 11;
  localparam int CFG_SETTLE_LSB = 8;
  localparam int CFG_PRE_LSB    = 5;
  localparam int CFG_SENSE_LSB  = 2;
  localparam int CFG_BGDET_BIT  = 1;
  localparam int CFG_LONG_BIT   = 0;
  localparam logic [15:0] CFG0_WRITE_RESET = 16'h0000;
  localparam logic [15:0] CFG0_READ_RESET  = 16'h4000;
  localparam logic [3:0]  AUTO_SCAN_MAX_CODE = 4'h1;

  typedef enum logic [0:0] {ST_CMD = 1'b0, ST_WORD = 1'b1} tac_state_t;
  typedef enum logic [1:0] {
    PH_SETTLE = 2'h0, PH_PRECHARGE = 2'h1, PH_SENSE = 2'h3, PH_SAMPLE = 2'h2
  } tac_phase_t;
endpackage

// >>> tac_register_port.sv
// Serial register port and configuration register zero of the touch converter.
// Assumes the converter core supplies results, busy, pen state and phase requests.
`timescale 1ns/10ps
module tac_register_port
  import tac_pkg::*;
#(
  parameter int unsigned SETTLE_CYC [8] = '{ns_to_cyc(SETTLE_NS[0]), ns_to_cyc(SETTLE_NS[1]),
    ns_to_cyc(SETTLE_NS[2]), ns_to_cyc(SETTLE_NS[3]), ns_to_cyc(SETTLE_NS[4]),
    ns_to_cyc(SETTLE_NS[5]), ns_to_cyc(SETTLE_NS[6]), ns_to_cyc(SETTLE_NS[7])},
  parameter int unsigned PRECHARGE_CYC [8] = '{ns_to_cyc(PRECHARGE_NS[0]),
    ns_to_cyc(PRECHARGE_NS[1]), ns_to_cyc(PRECHARGE_NS[2]), ns_to_cyc(PRECHARGE_NS[3]),
    ns_to_cyc(PRECHARGE_NS[4]), ns_to_cyc(PRECHARGE_NS[5]), ns_to_cyc(PRECHARGE_NS[6]),
    ns_to_cyc(PRECHARGE_NS[7])},
  parameter int unsigned SENSE_CYC [8] = '{ns_to_cyc(SENSE_NS[0]), ns_to_cyc(SENSE_NS[1]),
    ns_to_cyc(SENSE_NS[2]), ns_to_cyc(SENSE_NS[3]), ns_to_cyc(SENSE_NS[4]),
    ns_to_cyc(SENSE_NS[5]), ns_to_cyc(SENSE_NS[6]), ns_to_cyc(SENSE_NS[7])}
)(
  // Clock and reset.
  input  wire logic        clock,
  input  wire logic        rst,
  // Serial port.
  input  wire logic        sclk,
  input  wire logic        cs_n,
  input  wire logic        mosi,
  output logic             miso,
  output logic             miso_oe,
  // Converter core state.
  input  wire logic        pen_down,
  input  wire logic        conv_busy,
  input  wire logic [3:0]  converter_function_code,
  input  wire logic [11:0] conv_result [7],
  input  wire logic [15:0] status_word,
  input  wire logic [15:0] func_status_word,
  input  wire logic        irq_level,
  input  wire logic        osc_tick,
  // Conversion-start byte writes.
  input  wire logic        cb1_stop_we,
  input  wire logic        cb1_stop,
  input  wire logic        cb1_res_we,
  input  wire logic        cb1_res,
  output logic [7:0]       cb1_byte,
  output logic             cb1_byte_valid,
  // Phase timing.
  input  wire logic        phase_start,
  input  wire tac_phase_t  phase_sel,
  output logic             phase_running,
  output logic             phase_done,
  // Configuration to the converter core.
  output logic             auto_scan_en,
  output logic             conv_stop,
  output logic             conv_abort,
  output logic             resolution_select,
  output logic [1:0]       adc_clock_divider,
  output logic             adc_clock_tick,
  output logic             long_sample_mode,
  output logic             bias_keep_on,
  output logic             pen_data_irq_pin
);
  import tac_pkg::*;

  // Right-adjusts a result to the selected resolution.
  function automatic logic [15:0] fmt_result(input logic [11:0] r, input logic res12);
    return res12 ? {4'h0, r} : {6'h00, r[11:2]};
  endfunction

  // Last count of the oscillator divider for a clock code.
  function automatic logic [1:0] div_last(input logic [1:0] code);
    return (code == 2'h0) ? 2'h0 : (code == 2'h1) ? 2'h1 : 2'h3;
  endfunction

  logic              sclk_rise;
  logic              sclk_fall;
  logic              mosi_bit;
  logic              selected;
  tac_state_t        state;
  logic [3:0]        bit_cnt;
  logic [15:0]       rx;
  logic [15:0]       tx;
  logic [3:0]        addr;
  logic              rw;
  logic [15:0]       cfg0;
  logic [15:0]       thr [4];
  logic [1:0]        div_cnt;

  tac_spi_front u_front (
    .clock     (clock),
    .rst       (rst),
    .sclk      (sclk),
    .cs_n      (cs_n),
    .mosi      (mosi),
    .sclk_rise (sclk_rise),
    .sclk_fall (sclk_fall),
    .mosi_bit  (mosi_bit),
    .selected  (selected)
  );

  wire logic [15:0] next_rx   = {rx[14:0], mosi_bit};
  wire logic        cmd_fire  = sclk_rise & (state == ST_CMD) & (bit_cnt == CMD_LAST_BIT);
  wire logic        word_end  = sclk_rise & (state == ST_WORD) & (bit_cnt == WORD_LAST_BIT);
  wire logic        is_access = ~next_rx[CMD_ID_BIT];
  wire logic [3:0]  cmd_addr  = next_rx[CMD_ADDR_MSB:CMD_ADDR_LSB];
  wire logic        cmd_read  = next_rx[CMD_RW_BIT];
  wire logic        wr_fire   = word_end & ~rw;
  wire logic        wr_cfg0   = wr_fire & (addr == ADDR_CFG0);
  wire logic        is_thr    = (addr >= ADDR_THR_FIRST) & (addr <= ADDR_THR_LAST);
  wire logic        wr_thr    = wr_fire & is_thr;
  wire logic [15:0] cfg0_read = {pen_down, ~conv_busy, cfg0[CFG_RES_BIT:0]};
  wire logic        bg_idle   = cfg0[CFG_BGDET_BIT] & ~cfg0[CFG_SCAN_BIT] & ~conv_busy;

  // Readback word for the address in the command byte being completed.
  wire logic [15:0] rd_word =
    (cmd_addr < ADDR_STATUS) ? fmt_result(conv_result[cmd_addr[2:0]], cfg0[CFG_RES_BIT]) :
    (cmd_addr == ADDR_STATUS) ? status_word :
    (cmd_addr >= ADDR_THR_FIRST && cmd_addr <= ADDR_THR_LAST) ? thr[cmd_addr[1:0]] :
    (cmd_addr == ADDR_CFG0) ? cfg0_read :
    (cmd_addr == ADDR_FSTAT) ? func_status_word : 16'h0000;

  // Serial framing: command byte, then one data word for an access command, repeated while selected.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state          <= ST_CMD;
      bit_cnt        <= 4'h0;
      rx             <= 16'h0000;
      addr           <= 4'h0;
      rw             <= 1'b0;
      bias_keep_on   <= 1'b0;
      cb1_byte       <= 8'h00;
      cb1_byte_valid <= 1'b0;
    end else begin
      cb1_byte_valid <= 1'b0;
      if (!selected) begin
        state   <= ST_CMD;
        bit_cnt <= 4'h0;
      end else if (sclk_rise) begin
        rx      <= next_rx;
        bit_cnt <= bit_cnt + 4'h1;
        if (cmd_fire) begin
          bit_cnt <= 4'h0;
          if (is_access) begin
            state        <= ST_WORD;
            addr         <= cmd_addr;
            rw           <= cmd_read;
            bias_keep_on <= next_rx[CMD_BIAS_BIT];
          end else begin
            cb1_byte       <= next_rx[7:0];
            cb1_byte_valid <= 1'b1;
          end
        end else if (word_end) begin
          bit_cnt <= 4'h0;
          state   <= ST_CMD;
        end
      end
    end
  end

  // Read data launches on falling serial clock edges, MSB first.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      tx      <= 16'h0000;
      miso    <= 1'b0;
      miso_oe <= 1'b0;
    end else begin
      miso_oe <= selected & (state == ST_WORD) & rw;
      if (cmd_fire && is_access && cmd_read) begin
        tx <= rd_word;
      end else if (sclk_fall && state == ST_WORD && rw) begin
        miso <= tx[15];
        tx   <= {tx[14:0], 1'b0};
      end
    end
  end

  // Writable registers; conversion-start writes lose to a serial write.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cfg0       <= CFG0_WRITE_RESET;
      thr        <= '{default: 16'h0000};
      conv_abort <= 1'b0;
    end else begin
      conv_abort <= (wr_cfg0 & next_rx[CFG_STOP_BIT]) | (cb1_stop_we & cb1_stop);
      if (cb1_stop_we) begin
        cfg0[CFG_STOP_BIT] <= cb1_stop;
      end
      if (cb1_res_we) begin
        cfg0[CFG_RES_BIT] <= cb1_res;
      end
      if (wr_cfg0) begin
        cfg0 <= next_rx;
      end
      if (wr_thr) begin
        thr[addr[1:0]] <= next_rx;
      end
    end
  end

  // Converter-side outputs derived from the configuration.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      auto_scan_en      <= 1'b0;
      conv_stop         <= 1'b0;
      resolution_select <= 1'b0;
      adc_clock_divider <= 2'h0;
      long_sample_mode  <= 1'b0;
      pen_data_irq_pin  <= 1'b0;
    end else begin
      auto_scan_en      <= cfg0[CFG_SCAN_BIT] &
                           (converter_function_code <= AUTO_SCAN_MAX_CODE);
      conv_stop         <= cfg0[CFG_STOP_BIT];
      resolution_select <= cfg0[CFG_RES_BIT];
      adc_clock_divider <= cfg0[CFG_CLK_LSB+1:CFG_CLK_LSB];
      long_sample_mode  <= cfg0[CFG_LONG_BIT];
      pen_data_irq_pin  <= bg_idle ? ~pen_down : irq_level;
    end
  end

  // Converter clock tick: oscillator divided by 1, 2 or 4.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      div_cnt        <= 2'h0;
      adc_clock_tick <= 1'b0;
    end else begin
      adc_clock_tick <= 1'b0;
      if (osc_tick) begin
        if (div_cnt >= div_last(adc_clock_divider)) begin
          div_cnt        <= 2'h0;
          adc_clock_tick <= 1'b1;
        end else begin
          div_cnt <= div_cnt + 2'h1;
        end
      end
    end
  end

  // Phase length from the settle, precharge, sense and long-sample fields.
  wire logic [2:0] settle_code = cfg0[CFG_SETTLE_LSB+2:CFG_SETTLE_LSB];
  wire logic [2:0] pre_code    = cfg0[CFG_PRE_LSB+2:CFG_PRE_LSB];
  wire logic [2:0] sense_code  = cfg0[CFG_SENSE_LSB+2:CFG_SENSE_LSB];
  wire logic [TIMER_W-1:0] phase_count =
    (phase_sel == PH_SETTLE)    ? TIMER_W'(SETTLE_CYC[settle_code]) :
    (phase_sel == PH_PRECHARGE) ? TIMER_W'(PRECHARGE_CYC[pre_code]) :
    (phase_sel == PH_SENSE)     ? TIMER_W'(SENSE_CYC[sense_code]) :
    cfg0[CFG_LONG_BIT] ? TIMER_W'(LONG_SAMPLE_CYC) : TIMER_W'(SHORT_SAMPLE_CYC);

  tac_delay_timer u_timer (
    .clock   (clock),
    .rst     (rst),
    .start   (phase_start & ~cfg0[CFG_STOP_BIT]),
    .count   (phase_count),
    .running (phase_running),
    .done    (phase_done)
  );

  cmd_decode_a: assert property (@(posedge clock) disable iff (rst)
    cmd_fire && is_access |=> state == ST_WORD && bit_cnt == 4'h0)
    else $error("access command did not open a data word");

  read_launch_a: assert property (@(posedge clock) disable iff (rst)
    cmd_fire && is_access && cmd_read |=> tx == $past(rd_word) ##1 miso_oe)
    else $error("read word not loaded for shifting");

  cfg_write_a: assert property (@(posedge clock) disable iff (rst)
    wr_cfg0 |=> cfg0 == $past(next_rx))
    else $error("configuration write not stored");

  word_close_a: assert property (@(posedge clock) disable iff (rst)
    word_end |=> state == ST_CMD && bit_cnt == 4'h0)
    else $error("data word did not return to command framing");

  pad_zero_a: assert property (@(posedge clock) disable iff (rst)
    cmd_fire && is_access && cmd_read && cmd_addr < ADDR_STATUS && !cfg0[CFG_RES_BIT]
    |=> tx[15:10] == 6'h00)
    else $error("10-bit result not padded with six zeros");

  status_read_a: assert property (@(posedge clock) disable iff (rst)
    cmd_fire && is_access && cmd_read && cmd_addr == ADDR_CFG0
    |=> tx[CFG_STOP_BIT] == !$past(conv_busy) && tx[CFG_SCAN_BIT] == $past(pen_down))
    else $error("busy or pen status read wrongly");

  stop_abort_a: assert property (@(posedge clock) disable iff (rst)
    wr_cfg0 && next_rx[CFG_STOP_BIT] |=> conv_abort ##1 conv_stop)
    else $error("stop write did not abort the converter");

  scan_gate_a: assert property (@(posedge clock) disable iff (rst)
    auto_scan_en |-> $past(cfg0[CFG_SCAN_BIT]) && $past(converter_function_code) <= 4'h1)
    else $error("device scan enabled with an illegal function code");

  idle_pin_a: assert property (@(posedge clock) disable iff (rst)
    bg_idle && !pen_down |=> pen_data_irq_pin)
    else $error("pen pin not high while idle without touch");

  reset_read_a: assert property (@(posedge clock)
    $fell(rst) && !conv_busy && !pen_down |-> cfg0_read == CFG0_READ_RESET)
    else $error("configuration zero does not read its reset value");

  tick_code0_a: assert property (@(posedge clock) disable iff (rst)
    osc_tick && adc_clock_divider == 2'h0 |=> adc_clock_tick)
    else $error("undivided converter clock missed a tick");

  start_res_a: assert property (@(posedge clock) disable iff (rst)
    cb1_res_we && !wr_cfg0 |=> cfg0[CFG_RES_BIT] == $past(cb1_res))
    else $error("start byte resolution write not stored");

  start_stop_a: assert property (@(posedge clock) disable iff (rst)
    cb1_stop_we && !wr_cfg0 |=> cfg0[CFG_STOP_BIT] == $past(cb1_stop))
    else $error("start byte stop write not stored");

  phase_run_a: assert property (@(posedge clock) disable iff (rst)
    phase_start && !cfg0[CFG_STOP_BIT] |=> phase_running)
    else $error("phase timer did not start");

  stop_block_a: assert property (@(posedge clock) disable iff (rst)
    phase_start && cfg0[CFG_STOP_BIT] && !phase_running |=> !phase_running)
    else $error("phase timer started while stopped");

  long_sample_a: assert property (@(posedge clock) disable iff (rst)
    phase_start && phase_sel == PH_SAMPLE && cfg0[CFG_LONG_BIT] && !cfg0[CFG_STOP_BIT]
    |=> phase_running [*8])
    else $error("long sampling phase too short");

  short_sample_a: assert property (@(posedge clock) disable iff (rst)
    phase_start && phase_sel == PH_SAMPLE && !cfg0[CFG_LONG_BIT] && !cfg0[CFG_STOP_BIT]
    |=> ##1 phase_done)
    else $error("short sampling phase not one cycle");

  miso_shift_a: assert property (@(posedge clock) disable iff (rst)
    sclk_fall && state == ST_WORD && rw |=> miso == $past(tx[15]))
    else $error("read bit not launched on the falling edge");

  oe_release_a: assert property (@(posedge clock) disable iff (rst)
    !selected |=> !miso_oe)
    else $error("data output driven while deselected");

  cfg_keep_a: assert property (@(posedge clock) disable iff (rst)
    wr_fire && addr != ADDR_CFG0 && !cb1_stop_we && !cb1_res_we |=> cfg0 == $past(cfg0))
    else $error("write to another address changed the configuration");

  bias_latch_a: assert property (@(posedge clock) disable iff (rst)
    cmd_fire && is_access |=> bias_keep_on == $past(next_rx[CMD_BIAS_BIT]))
    else $error("bias keep-on bit not taken from the command");

  start_byte_a: assert property (@(posedge clock) disable iff (rst)
    cmd_fire && !is_access |=> cb1_byte_valid && state == ST_CMD)
    else $error("conversion-start byte opened a data word");

  host_pin_a: assert property (@(posedge clock) disable iff (rst)
    !bg_idle |=> pen_data_irq_pin == $past(irq_level))
    else $error("pen pin not following the interrupt level");

  scan_on_a: assert property (@(posedge clock) disable iff (rst)
    cfg0[CFG_SCAN_BIT] && converter_function_code <= AUTO_SCAN_MAX_CODE |=> auto_scan_en)
    else $error("device scan not enabled with a legal function code");
endmodule

// >>> tac_spi_front.sv
// Edge detector for the serial port pins.
// Assumes serial pins are synchronous to the system clock.
`timescale 1ns/10ps
module tac_spi_front (
  // Clock and reset.
  input  wire logic clock,
  input  wire logic rst,
  // Serial pins.
  input  wire logic sclk,
  input  wire logic cs_n,
  input  wire logic mosi,
  // Decoded events.
  output wire logic sclk_rise,
  output wire logic sclk_fall,
  output wire logic mosi_bit,
  output wire logic selected
);
  logic sclk_q;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sclk_q <= 1'b0;
    end else begin
      sclk_q <= sclk;
    end
  end

  assign selected  = ~cs_n;
  assign sclk_rise = selected & sclk & ~sclk_q;
  assign sclk_fall = selected & ~sclk & sclk_q;
  assign mosi_bit  = mosi;
endmodule

// >>> test_tac_register_port.sv
// Self-checking bench of the register port with a host serial master model.
// Assumes short phase-timer tables so timing checks stay brief.
`timescale 1ns/10ps
module test_tac_register_port;
  import tac_pkg::*;
  logic        clock, rst, sclk, cs_n, mosi, miso, miso_oe, pen_down, conv_busy;
  logic        irq_level, osc_tick, stop_we, stop_v, res_we, res_v, phase_start;
  logic        cb1_valid, ph_run, ph_done, auto_scan, conv_stop, conv_abort;
  logic        res_sel, long_s, bias, irq_pin, adc_tick;
  logic [1:0]  div;
  logic [3:0]  fcode;
  logic [7:0]  cb1_byte;
  logic [11:0] result [7];
  logic [15:0] status_word, rd;
  tac_phase_t  phase_sel;
  int          error_cnt, n_checks, cycles, ticks, aborts, oe_cnt, cb1_cnt;

  tac_register_port #(.SETTLE_CYC('{1, 2, 3, 4, 5, 6, 7, 8}),
    .PRECHARGE_CYC('{1, 2, 3, 4, 5, 6, 7, 8}), .SENSE_CYC('{1, 2, 3, 4, 5, 6, 7, 8})) uut (
    .clock(clock), .rst(rst), .sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso),
    .miso_oe(miso_oe), .pen_down(pen_down), .conv_busy(conv_busy),
    .converter_function_code(fcode), .conv_result(result), .status_word(status_word),
    .func_status_word(16'h5A3C), .irq_level(irq_level), .osc_tick(osc_tick),
    .cb1_stop_we(stop_we), .cb1_stop(stop_v), .cb1_res_we(res_we), .cb1_res(res_v),
    .cb1_byte(cb1_byte), .cb1_byte_valid(cb1_valid), .phase_start(phase_start),
    .phase_sel(phase_sel), .phase_running(ph_run), .phase_done(ph_done),
    .auto_scan_en(auto_scan), .conv_stop(conv_stop), .conv_abort(conv_abort),
    .resolution_select(res_sel), .adc_clock_divider(div), .adc_clock_tick(adc_tick),
    .long_sample_mode(long_s), .bias_keep_on(bias), .pen_data_irq_pin(irq_pin));

  tac_host_model host (.clock(clock), .sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso));

  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  always @(posedge clock) begin
    cycles++;
    if (adc_tick === 1'b1) ticks++;
    if (conv_abort === 1'b1) aborts++;
    if (miso_oe === 1'b1) oe_cnt++;
    if (cb1_valid === 1'b1) cb1_cnt++;
    if (cycles == 30000) begin
      error_cnt++;
      summarize();
    end
  end

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  function automatic logic [7:0] cmd(input logic [3:0] a, input logic rw);
    return {1'b0, a, 1'b0, 1'b0, rw};
  endfunction

  task automatic wr_reg(input logic [3:0] a, input logic [15:0] v);
    logic [15:0] d;
    host.xfer(cmd(a, 1'b0), v, d);
  endtask

  task automatic rd_reg(input logic [3:0] a, input logic [15:0] exp, input string what);
    host.xfer(cmd(a, 1'b1), 16'h0000, rd);
    check(what, rd, exp);
  endtask

  task automatic t_reset();
    oe_cnt = 0;
    rd_reg(ADDR_CFG0, 16'h4000, "cfg0 after reset");
    check("drive cycles", 16'(oe_cnt), 16'h0080);
    check("resolution", {15'h0, res_sel}, 16'h0000);
    host.release_bus();
    $display("test reset done");
  endtask

  task automatic t_cfg();
    host.xfer(cmd(ADDR_CFG0, 1'b0) | 8'h02, 16'h2F6B, rd);
    check("bias", {15'h0, bias}, 16'h0001);
    rd_reg(ADDR_CFG0, 16'h6F6B, "cfg0 readback");
    check("resolution", {15'h0, res_sel}, 16'h0001);
    check("clock code", {14'h0, div}, 16'h0001);
    check("long sample", {15'h0, long_s}, 16'h0001);
    // A host polling this high may skip its conversion command.
    check("pen pin idle", {15'h0, irq_pin}, 16'h0001);
    pen_down = 1'b1;
    conv_busy = 1'b1;
    irq_level = 1'b1;
    repeat (3) @(negedge clock);
    rd_reg(ADDR_CFG0, 16'hAF6B, "cfg0 touched busy");
    check("pen pin busy", {15'h0, irq_pin}, 16'h0001);
    pen_down = 1'b0;
    conv_busy = 1'b0;
    irq_level = 1'b0;
    host.release_bus();
    $display("test config done");
  endtask

  task automatic t_div();
    int exp [4] = '{24, 12, 6, 6};
    for (int c = 0; c < 4; c++) begin
      wr_reg(ADDR_CFG0, 16'(c) << CFG_CLK_LSB);
      repeat (4) @(negedge clock);
      ticks = 0;
      repeat (24) begin
        @(negedge clock) osc_tick = 1'b1;
        @(negedge clock) osc_tick = 1'b0;
        @(negedge clock);
      end
      repeat (3) @(negedge clock);
      check("adc ticks", 16'(ticks), 16'(exp[c]));
    end
    host.release_bus();
    $display("test divider done");
  endtask

  task automatic t_regs();
    result[0] = 12'hABC;
    status_word = 16'h1234;
    wr_reg(ADDR_CFG0, 16'h2000);
    wr_reg(4'h0, 16'hFFFF);
    wr_reg(ADDR_STATUS, 16'hFFFF);
    wr_reg(ADDR_THR_FIRST, 16'hBEEF);
    rd_reg(4'h0, 16'h0ABC, "result 12 bit");
    rd_reg(ADDR_STATUS, 16'h1234, "status");
    rd_reg(ADDR_THR_FIRST, 16'hBEEF, "threshold");
    rd_reg(4'hD, 16'h0000, "unmapped");
    rd_reg(ADDR_FSTAT, 16'h5A3C, "function status");
    wr_reg(ADDR_CFG0, 16'h0000);
    rd_reg(4'h0, 16'h02AF, "result 10 bit");
    host.release_bus();
    $display("test registers done");
  endtask

  task automatic t_stop();
    int n;
    aborts = 0;
    wr_reg(ADDR_CFG0, 16'h4300);
    repeat (4) @(negedge clock);
    check("abort pulses", 16'(aborts), 16'h0001);
    check("stop", {15'h0, conv_stop}, 16'h0001);
    phase_sel = PH_SETTLE;
    phase_start = 1'b1;
    @(negedge clock) phase_start = 1'b0;
    repeat (2) @(negedge clock);
    check("phase while stopped", {15'h0, ph_run}, 16'h0000);
    wr_reg(ADDR_CFG0, 16'h0300);
    repeat (4) @(negedge clock);
    phase_len(PH_SETTLE, n);
    check("settle cycles", 16'(n), 16'h0005);
    stop_v = 1'b1;
    stop_we = 1'b1;
    @(negedge clock) stop_we = 1'b0;
    res_v = 1'b1;
    res_we = 1'b1;
    @(negedge clock) res_we = 1'b0;
    repeat (2) @(negedge clock);
    check("start byte stop", {15'h0, conv_stop}, 16'h0001);
    rd_reg(ADDR_CFG0, 16'h6300, "cfg0 after start byte");
    wr_reg(ADDR_CFG0, 16'h0000);
    host.release_bus();
    $display("test stop done");
  endtask

  task automatic t_scan();
    fcode = 4'h0;
    wr_reg(ADDR_CFG0, 16'h8000);
    repeat (3) @(negedge clock);
    check("auto scan code 0", {15'h0, auto_scan}, 16'h0001);
    fcode = 4'h2;
    repeat (3) @(negedge clock);
    check("auto scan code 2", {15'h0, auto_scan}, 16'h0000);
    rd_reg(ADDR_CFG0, 16'h4000, "pen state no touch");
    host.release_bus();
    $display("test scan done");
  endtask

  // Counts falling edges from a start pulse to the done pulse.
  task automatic phase_len(input tac_phase_t sel, output int n);
    phase_sel = sel;
    phase_start = 1'b1;
    @(negedge clock) phase_start = 1'b0;
    n = 1;
    while (ph_done !== 1'b1 && n < 50) begin
      @(negedge clock);
      n++;
    end
  endtask

  task automatic t_phase();
    int n;
    wr_reg(ADDR_CFG0, 16'h00B9);
    repeat (4) @(negedge clock);
    phase_len(PH_PRECHARGE, n);
    check("precharge cycles", 16'(n), 16'h0007);
    phase_len(PH_SENSE, n);
    check("sense cycles", 16'(n), 16'h0008);
    phase_len(PH_SAMPLE, n);
    check("long sample cycles", 16'(n), 16'(LONG_SAMPLE_CYC + 1));
    wr_reg(ADDR_CFG0, 16'h0000);
    repeat (4) @(negedge clock);
    phase_len(PH_SAMPLE, n);
    check("short sample cycles", 16'(n), 16'(SHORT_SAMPLE_CYC + 1));
    host.release_bus();
    $display("test phases done");
  endtask

  task automatic t_start();
    cb1_cnt = 0;
    host.xfer(8'h9A, 16'h9A9A, rd);
    repeat (2) @(negedge clock);
    check("start byte", {8'h00, cb1_byte}, 16'h009A);
    check("start byte pulses", 16'(cb1_cnt), 16'h0003);
    host.release_bus();
    $display("test start byte done");
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  initial begin
    rst = 1'b1;
    {pen_down, conv_busy, irq_level, osc_tick, stop_we, stop_v, res_we, res_v} = 8'h00;
    phase_start = 1'b0;
    phase_sel = PH_SETTLE;
    fcode = 4'h0;
    status_word = 16'h0000;
    for (int i = 0; i < 7; i++) result[i] = 12'(i);
    repeat (20) @(negedge clock);
    rst = 1'b0;
    repeat (2) @(negedge clock);
    t_reset();
    t_cfg();
    t_div();
    t_regs();
    t_stop();
    t_scan();
    t_phase();
    t_start();
    summarize();
  end
endmodule
